// >>> rtl/eeprom_slave_pkg.sv
package eeprom_slave_pkg;

    // ==========================================================
    // Control byte codes and bits per byte
    localparam logic [3:0] CTRL_NORMAL = 4'hA;
    localparam logic [3:0] CTRL_WPROT = 4'h6;
    localparam logic [3:0] BYTE_BITS = 4'h8;

    // ==========================================================
    // Storage
    localparam int PAGE_DEPTH = 16;
    localparam int ENTRY_W = 16;
    localparam logic [7:0] LOW_HALF_TOP = 8'h7F;

    // ==========================================================
    // Timing
    localparam int CLK_MHZ = 40;
    localparam int OUT_HOLD_NS = 300;
    localparam logic [3:0] OUT_HOLD_CYC = 4'((OUT_HOLD_NS * CLK_MHZ + 999) / 1000);
    localparam int WR_CYCLE_MS = 10;
    localparam int WR_CYCLE_CYC = WR_CYCLE_MS * CLK_MHZ * 1000;
    localparam int TMR_W = 19;

    // ==========================================================
    // Protocol states
    typedef enum logic [5:0] {
        ST_IDLE = 6'b000001,
        ST_RX = 6'b000010,
        ST_ACK = 6'b000100,
        ST_TX = 6'b001000,
        ST_TXACK = 6'b010000,
        ST_SKIP = 6'b100000
    } proto_state_t;

    typedef enum logic [1:0] {
        ROLE_CTRL = 2'h0,
        ROLE_ADDR = 2'h1,
        ROLE_DATA = 2'h2
    } byte_role_t;

endpackage

// >>> rtl/page_fifo_if.sv
`timescale 1ns/1ps
interface page_fifo_if #(parameter int W = 16);
    logic in_valid;
    logic in_ready;
    logic [W-1:0] in_data;
    logic out_valid;
    logic out_ready;
    logic [W-1:0] out_data;
    logic full;

    modport user (output in_valid, in_data, out_ready,
                  input in_ready, out_valid, out_data, full);
    modport store (input in_valid, in_data, out_ready,
                   output in_ready, out_valid, out_data, full);
endinterface

// >>> rtl/pin_sync.sv
`timescale 1ns/1ps
module pin_sync
#(
    parameter int N = 6
)
(
    // Clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // Pins in, synchronised levels out
    input wire logic [N-1:0] pins,
    output logic [N-1:0] levels
);
    logic [N-1:0] first_q;
    logic [N-1:0] second_q;

    // ==========================================================
    // Two flops per pin; the first is read by the second only
    for (genvar i = 0; i < N; i++)
    begin : g_bit
        always_ff @(posedge clock or negedge reset_n)
        begin
            if (!reset_n)
            begin
                first_q[i] <= 1'b1;
                second_q[i] <= 1'b1;
            end
            else
            begin
                first_q[i] <= pins[i];
                second_q[i] <= first_q[i];
            end
        end
    end

    assign levels = second_q;
endmodule

// >>> rtl/page_fifo.sv
`timescale 1ns/1ps
module page_fifo
#(
    parameter int W = 16,
    parameter int D = 16
)
(
    // Clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // Both sides
    page_fifo_if.store q
);
    localparam int AW = $clog2(D);

    logic [W-1:0] mem [D];
    logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
    logic [AW:0] cnt_q, cnt_d;
    logic push, pop;

    // ==========================================================
    // Pointers and fill level
    assign q.full = (cnt_q == (AW+1)'(D));
    assign q.out_valid = (cnt_q != '0);
    // Full accepts a push only when the oldest leaves together
    assign q.in_ready = !q.full || q.out_ready;
    assign q.out_data = mem[rd_q];
    assign push = q.in_valid && q.in_ready;
    assign pop = q.out_valid && q.out_ready;

    always_comb
    begin
        wr_d = push ? wr_q + 1'b1 : wr_q;
        rd_d = pop ? rd_q + 1'b1 : rd_q;
        cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end
        else
        begin
            wr_q <= wr_d;
            rd_q <= rd_d;
            cnt_q <= cnt_d;
        end
    end

    always_ff @(posedge clock)
    begin
        if (push)
        begin
            mem[wr_q] <= q.in_data;
        end
    end
endmodule

// >>> rtl/eeprom_slave.sv
// How it works
// [RL1] Master starts only on idle bus
// [RL2] SDA falling while SCL high is start
// [RL3] SDA rising while SCL high is stop
// [RL4] Data steady while SCL high
// [RL5] One bit per clock, sampled high
// [RL6] Keep newest sixteen bytes, oldest dropped
// [RL7] Acknowledge each byte on ninth clock
// [RL8] No acknowledge during write cycle
// [RL9] Acknowledge holds SDA low through high
// [RL10] Master nack ends read; release SDA
// [RL11] Codes 1010 normal, 0110 protect register
// [RL12] Chip select bits must match straps
// [RL13] Protect code with read not acknowledged
// [RL14] Eighth bit: one read, zero write
// [RL15] Second byte loads word address pointer
// [RL16] Stop after data starts write cycle
// [RL17] Protected writes acked, dropped, still timed
// [RL18] Output changes wait hold after fall
// [RL19] Counter times the busy write cycle
// [RL20] Software protect blocks addresses 00h-7Fh
// [RL21] Protect pin blocks whole array
// [RL22] Once protected, ignore protect code
`timescale 1ns/1ps
module eeprom_slave
    import eeprom_slave_pkg::*;
#(
    parameter int WR_CYCLE_CYC_P = WR_CYCLE_CYC
)
(
    // Clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // Two-wire bus
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // Straps and protect pin
    input wire logic chip_sel_strap_bit0,
    input wire logic chip_sel_strap_bit1,
    input wire logic chip_sel_strap_bit2,
    input wire logic wp_pin,
    // Commit to array
    output logic mem_valid,
    input wire logic mem_ready,
    output logic [7:0] mem_addr,
    output logic [7:0] mem_data,
    // Read data from array
    output logic [7:0] rd_addr,
    input wire logic [7:0] rd_data,
    // Status
    output logic busy,
    output logic wprot_set
);
    logic [5:0] lv;
    logic scl_s, sda_s, wp_s;
    logic [2:0] strap_s;
    page_fifo_if #(.W(ENTRY_W)) fq ();

    pin_sync #(.N(6)) u_sync (
        .clock(clock),
        .reset_n(reset_n),
        .pins({chip_sel_strap_bit2, chip_sel_strap_bit1, chip_sel_strap_bit0,
               wp_pin, sda_in, scl_in}),
        .levels(lv)
    );
    assign {strap_s, wp_s, sda_s, scl_s} = lv;

    page_fifo #(.W(ENTRY_W), .D(PAGE_DEPTH)) u_fifo (
        .clock(clock),
        .reset_n(reset_n),
        .q(fq)
    );

    proto_state_t st_q, st_d;
    byte_role_t role_q, role_d;
    logic scl_p_q, sda_p_q;
    logic [7:0] sh_q, sh_d, ptr_q, ptr_d;
    logic [3:0] cnt_q, cnt_d, hold_q, hold_d;
    logic rd_q, rd_d, wpm_q, wpm_d, pend_q, pend_d, more_q, more_d;
    logic tgt_q, tgt_d, oe_q, oe_d, busy_q, busy_d, swp_q, swp_d;
    logic [TMR_W-1:0] tmr_q, tmr_d;
    logic scl_rise, scl_fall, start_ev, stop_ev, ctrl_end, hit, acc_n, acc_w;
    logic push, prot, drain_pop;

    // ==========================================================
    // Bus events
    assign scl_rise = scl_s && !scl_p_q;
    assign scl_fall = !scl_s && scl_p_q;
    assign start_ev = scl_s && scl_p_q && sda_p_q && !sda_s; // RL2
    assign stop_ev = scl_s && scl_p_q && !sda_p_q && sda_s; // RL3
    assign ctrl_end = (st_q == ST_RX) && scl_fall && (cnt_q == BYTE_BITS)
                      && (role_q == ROLE_CTRL);
    assign hit = (sh_q[3:1] == strap_s) && !busy_q; // RL12 RL8
    assign acc_n = hit && (sh_q[7:4] == CTRL_NORMAL); // RL11
    assign acc_w = hit && (sh_q[7:4] == CTRL_WPROT) && !sh_q[0] && !swp_q; // RL13 RL22

    // ==========================================================
    // Page buffer and commit
    assign push = (st_q == ST_RX) && scl_fall && (cnt_q == BYTE_BITS)
                  && (role_q == ROLE_DATA) && !wpm_q;
    assign fq.in_valid = push;
    assign fq.in_data = {ptr_q, sh_q};
    assign mem_addr = fq.out_data[15:8];
    assign mem_data = fq.out_data[7:0];
    // Protection judged per byte as it leaves
    assign prot = wp_s || (swp_q && (mem_addr <= LOW_HALF_TOP)); // RL20 RL21
    assign mem_valid = busy_q && fq.out_valid && !prot; // RL17
    assign drain_pop = busy_q && fq.out_valid && (prot || mem_ready);
    // Overwrite the oldest when full; flush stale entries when idle
    assign fq.out_ready = drain_pop || (push && fq.full) // RL6
                          || (!busy_q && !pend_q && fq.out_valid);

    assign sda_out = 1'b0;
    assign sda_oe = oe_q;
    assign rd_addr = ptr_q;
    assign busy = busy_q;
    assign wprot_set = swp_q;

    // ==========================================================
    // Protocol next state
    always_comb
    begin
        st_d = st_q;
        role_d = role_q;
        sh_d = sh_q;
        ptr_d = ptr_q;
        cnt_d = cnt_q;
        rd_d = rd_q;
        wpm_d = wpm_q;
        pend_d = pend_q;
        more_d = more_q;
        tgt_d = tgt_q;
        unique case (st_q)
            ST_IDLE, ST_SKIP:
            begin
                tgt_d = 1'b0;
            end
            ST_RX:
            begin
                if (scl_rise)
                begin
                    sh_d = {sh_q[6:0], sda_s}; // RL5 RL4
                    cnt_d = cnt_q + 4'h1;
                end
                else if (scl_fall && cnt_q == BYTE_BITS)
                begin
                    cnt_d = 4'h0;
                    tgt_d = 1'b1; // RL7 RL9
                    st_d = ST_ACK;
                    unique case (role_q)
                        ROLE_CTRL:
                        begin
                            rd_d = sh_q[0] && acc_n; // RL14
                            wpm_d = acc_w;
                            pend_d = acc_w;
                            if (!(acc_n || acc_w))
                            begin
                                tgt_d = 1'b0;
                                st_d = ST_SKIP;
                            end
                        end
                        ROLE_ADDR:
                        begin
                            if (!wpm_q)
                            begin
                                ptr_d = sh_q; // RL15
                            end
                        end
                        default:
                        begin
                            ptr_d = {ptr_q[7:4], ptr_q[3:0] + 4'h1};
                            pend_d = 1'b1;
                        end
                    endcase
                end
            end
            ST_ACK:
            begin
                if (scl_fall)
                begin
                    if (rd_q)
                    begin
                        sh_d = rd_data;
                        tgt_d = !rd_data[7];
                        st_d = ST_TX;
                    end
                    else
                    begin
                        tgt_d = 1'b0;
                        st_d = ST_RX;
                        role_d = (role_q == ROLE_CTRL) ? ROLE_ADDR : ROLE_DATA;
                    end
                end
            end
            ST_TX:
            begin
                if (scl_rise)
                begin
                    cnt_d = cnt_q + 4'h1;
                end
                else if (scl_fall && cnt_q == BYTE_BITS)
                begin
                    cnt_d = 4'h0;
                    tgt_d = 1'b0;
                    ptr_d = ptr_q + 8'h01;
                    st_d = ST_TXACK;
                end
                else if (scl_fall)
                begin
                    sh_d = {sh_q[6:0], 1'b0};
                    tgt_d = !sh_q[6];
                end
            end
            ST_TXACK:
            begin
                if (scl_rise)
                begin
                    more_d = !sda_s;
                end
                else if (scl_fall)
                begin
                    // Master nack: line stays released for its stop
                    sh_d = rd_data; // RL10
                    tgt_d = more_q && !rd_data[7];
                    st_d = more_q ? ST_TX : ST_SKIP;
                end
            end
            default:
            begin
                st_d = ST_IDLE;
            end
        endcase
        if (start_ev)
        begin
            st_d = ST_RX;
            role_d = ROLE_CTRL;
            cnt_d = 4'h0;
            rd_d = 1'b0;
            wpm_d = 1'b0;
            pend_d = 1'b0;
            tgt_d = 1'b0;
        end
        else if (stop_ev)
        begin
            st_d = ST_IDLE;
            pend_d = 1'b0;
            tgt_d = 1'b0;
        end
    end

    // ==========================================================
    // Output hold, write cycle, protect register
    always_comb
    begin
        hold_d = scl_fall ? OUT_HOLD_CYC : (hold_q != 4'h0 ? hold_q - 4'h1 : hold_q);
        oe_d = (hold_q == 4'h1) ? tgt_q : oe_q; // RL18
        if (start_ev || stop_ev)
        begin
            oe_d = 1'b0;
        end
        busy_d = busy_q;
        tmr_d = tmr_q;
        swp_d = swp_q;
        if (busy_q)
        begin
            if (tmr_q != '0)
            begin
                tmr_d = tmr_q - 1'b1; // RL19
            end
            else if (!fq.out_valid)
            begin
                busy_d = 1'b0;
            end
        end
        else if (stop_ev && pend_q)
        begin
            busy_d = 1'b1; // RL16
            tmr_d = TMR_W'(WR_CYCLE_CYC_P);
            swp_d = swp_q || (wpm_q && !wp_s); // RL21
        end
    end

    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            st_q <= ST_IDLE;
            role_q <= ROLE_CTRL;
            scl_p_q <= 1'b1;
            sda_p_q <= 1'b1;
            sh_q <= 8'h00;
            ptr_q <= 8'h00;
            cnt_q <= 4'h0;
            rd_q <= 1'b0;
            wpm_q <= 1'b0;
            pend_q <= 1'b0;
            more_q <= 1'b0;
            tgt_q <= 1'b0;
            oe_q <= 1'b0;
            hold_q <= 4'h0;
            busy_q <= 1'b0;
            tmr_q <= '0;
            swp_q <= 1'b0;
        end
        else
        begin
            st_q <= st_d;
            role_q <= role_d;
            scl_p_q <= scl_s;
            sda_p_q <= sda_s;
            sh_q <= sh_d;
            ptr_q <= ptr_d;
            cnt_q <= cnt_d;
            rd_q <= rd_d;
            wpm_q <= wpm_d;
            pend_q <= pend_d;
            more_q <= more_d;
            tgt_q <= tgt_d;
            oe_q <= oe_d;
            hold_q <= hold_d;
            busy_q <= busy_d;
            tmr_q <= tmr_d;
            swp_q <= swp_d;
        end
    end

    // ==========================================================
    // Checks
    logic [3:0] since_fall_q;
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            since_fall_q <= 4'h0;
        end
        else
        begin
            since_fall_q <= scl_fall ? 4'h0 : (since_fall_q == 4'hF ? 4'hF : since_fall_q + 4'h1);
        end
    end

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!reset_n);

    property p_start;
        start_ev |=> st_q == ST_RX && cnt_q == 4'h0;
    endproperty
    a_start: assert property (p_start) else $error("start not taken"); // RL2

    property p_stop;
        stop_ev && !start_ev |=> st_q == ST_IDLE && !oe_q;
    endproperty
    a_stop: assert property (p_stop) else $error("stop not taken"); // RL3

    property p_busy_quiet;
        busy_q |-> !oe_q;
    endproperty
    a_busy_quiet: assert property (p_busy_quiet) else $error("drive while busy"); // RL8

    property p_hold;
        $rose(oe_q) |-> since_fall_q >= OUT_HOLD_CYC;
    endproperty
    a_hold: assert property (p_hold) else $error("output changed too early"); // RL18

    property p_cycle;
        stop_ev && pend_q && !busy_q |=> busy_q ##1 busy_q;
    endproperty
    a_cycle: assert property (p_cycle) else $error("write cycle not started"); // RL16

    property p_strap;
        ctrl_end && sh_q[3:1] != strap_s |=> st_q == ST_SKIP;
    endproperty
    a_strap: assert property (p_strap) else $error("foreign chip select acked"); // RL12

    property p_wp_read;
        ctrl_end && sh_q[7:4] == CTRL_WPROT && (sh_q[0] || swp_q) |=> st_q == ST_SKIP;
    endproperty
    a_wp_read: assert property (p_wp_read) else $error("protect code acked"); // RL13

    property p_low_half;
        mem_valid |-> !wp_s && !(swp_q && mem_addr <= LOW_HALF_TOP);
    endproperty
    a_low_half: assert property (p_low_half) else $error("protected byte committed"); // RL20

    property p_overwrite;
        push && fq.full |-> fq.out_ready && fq.in_ready;
    endproperty
    a_overwrite: assert property (p_overwrite) else $error("newest byte lost"); // RL6

    property p_addr;
        st_q == ST_RX && scl_fall && cnt_q == BYTE_BITS && role_q == ROLE_ADDR && !wpm_q
            |=> ptr_q == $past(sh_q);
    endproperty
    a_addr: assert property (p_addr) else $error("pointer not loaded"); // RL15

    c_write: cover property (stop_ev && pend_q && !wpm_q ##1 busy_q);
    c_read: cover property (st_q == ST_TXACK ##[1:200] st_q == ST_TX);
    c_wprot: cover property ($rose(swp_q));
    c_overwrite: cover property (push && fq.full);
endmodule

// >>> bench/bus_master.sv
`timescale 1ns/1ps
module bus_master
#(
    parameter int Q = 20
)
(
    // Clock
    input wire logic clock,
    // Shared open-drain data wire and bus clock
    input wire logic sda_dev_oe,
    output logic scl,
    output logic sda_line
);
    logic pull_q;

    // ==========================================================
    // Wire with pull-up: low if either side pulls
    assign sda_line = ~(pull_q | sda_dev_oe);

    initial
    begin
        scl = 1'b1;
        pull_q = 1'b0;
    end

    task automatic wait_q(input int n);
        repeat (n * Q) @(posedge clock);
    endtask

    // Called only on an idle bus, after reset or a stop, so both lines are high
    task automatic start();
        pull_q <= 1'b1;
        wait_q(2);
        scl <= 1'b0;
    endtask

    // Data moves halfway into the low phase, sampled at the end of high
    task automatic bit_io(input logic b, output logic r);
        wait_q(1);
        pull_q <= ~b;
        wait_q(1);
        scl <= 1'b1;
        wait_q(2);
        r = sda_line;
        scl <= 1'b0;
    endtask

    task automatic stop();
        wait_q(1);
        pull_q <= 1'b1;
        wait_q(1);
        scl <= 1'b1;
        wait_q(2);
        pull_q <= 1'b0;
        wait_q(2);
    endtask

    task automatic write_byte(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_io(b[i], r);
        bit_io(1'b1, r);
        ack = ~r;
    endtask

    // Master acks by holding low through the ninth high, or nacks the last byte
    task automatic read_byte(input logic ack_it, output logic [7:0] b);
        logic r;
        for (int i = 0; i < 8; i++)
        begin
            bit_io(1'b1, r);
            b = {b[6:0], r};
        end
        bit_io(~ack_it, r);
    endtask
endmodule

// >>> bench/tb.sv
`timescale 1ns/1ps
module tb;
    import eeprom_slave_pkg::*;
    localparam int WR_CYC = 50;
    logic clock;
    logic reset_n;
    logic [2:0] strap;
    logic wp_pin;
    logic mem_ready;
    logic scl;
    logic sda_line;
    logic sda_oe;
    logic sda_out;
    logic mem_valid;
    logic [7:0] mem_addr;
    logic [7:0] mem_data;
    logic [7:0] rd_addr;
    logic [7:0] rd_data;
    logic busy;
    logic wprot_set;
    logic saw_valid;
    logic oe_prev;
    int low_cnt;
    int err_count;
    int checks_done;

    // Array model: each word holds its inverted address
    assign rd_data = ~rd_addr;

    eeprom_slave #(.WR_CYCLE_CYC_P(WR_CYC)) dut (
        .clock(clock), .reset_n(reset_n), .scl_in(scl), .sda_in(sda_line),
        .sda_out(sda_out), .sda_oe(sda_oe), .chip_sel_strap_bit0(strap[0]),
        .chip_sel_strap_bit1(strap[1]), .chip_sel_strap_bit2(strap[2]),
        .wp_pin(wp_pin), .mem_valid(mem_valid), .mem_ready(mem_ready),
        .mem_addr(mem_addr), .mem_data(mem_data), .rd_addr(rd_addr),
        .rd_data(rd_data), .busy(busy), .wprot_set(wprot_set));

    bus_master m (.clock(clock), .sda_dev_oe(sda_oe), .scl(scl), .sda_line(sda_line));

    initial
    begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            err_count++;
            $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic summarize();
        $display("errors %0d checks %0d", err_count, checks_done);
        if (err_count == 0 && checks_done > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // ==========================================================
    // Wire watch: device moves SDA only in clock low, after the hold delay
    always @(posedge clock)
    begin
        low_cnt <= scl ? 0 : low_cnt + 1;
        oe_prev <= sda_oe;
        if (mem_valid === 1'b1)
            saw_valid <= 1'b1;
        if (reset_n && sda_oe !== oe_prev && (scl || low_cnt < int'(OUT_HOLD_CYC)))
            check(sda_oe, oe_prev);
    end

    // ==========================================================
    // Helpers
    function automatic logic [7:0] ctl(input logic [3:0] code, input logic rw);
        return {code, strap, rw};
    endfunction

    task automatic xfer(input logic [7:0] b[$], output int n);
        logic a;
        n = 0;
        m.start();
        foreach (b[i])
        begin
            m.write_byte(b[i], a);
            if (a !== 1'b1)
                break;
            n++;
        end
        m.stop();
    endtask

    task automatic commit(input logic [7:0] a, input logic [7:0] d);
        int n;
        n = 0;
        // Step past the edge that may have just retired the previous entry
        #1;
        while (mem_valid !== 1'b1 && n < 3000)
        begin
            @(posedge clock);
            #1;
            n++;
        end
        check({mem_valid, mem_addr, mem_data}, {1'b1, a, d});
        @(posedge clock);
        mem_ready <= 1'b1;
        @(posedge clock);
        mem_ready <= 1'b0;
    endtask

    task automatic wait_idle();
        int n;
        n = 0;
        while (busy !== 1'b0 && n < 5000)
        begin
            @(posedge clock);
            n++;
        end
        #1;
        check(busy, 1'b0);
    endtask

    // ==========================================================
    // Scenarios
    task automatic t_byte_write();
        int n;
        xfer('{ctl(CTRL_NORMAL, 1'b0), 8'h85, 8'h3C}, n);
        check(n, 3);
        check(busy, 1'b1);
        xfer('{ctl(CTRL_NORMAL, 1'b0)}, n);
        check(n, 0);
        commit(8'h85, 8'h3C);
        wait_idle();
        check(rd_addr, 8'h86);
    endtask

    task automatic t_select();
        int n;
        for (int cs = 0; cs < 8; cs++)
        begin
            if (3'(cs) == strap)
                continue;
            xfer('{{CTRL_NORMAL, 3'(cs), 1'b0}}, n);
            check(n, 0);
        end
        xfer('{ctl(4'h5, 1'b0)}, n);
        check(n, 0);
        xfer('{ctl(CTRL_WPROT, 1'b1)}, n);
        check(n, 0);
    endtask

    task automatic t_page();
        logic [7:0] q[$];
        int n;
        q = '{ctl(CTRL_NORMAL, 1'b0), 8'h90};
        for (int i = 0; i < 18; i++)
            q.push_back(8'(i));
        xfer(q, n);
        check(n, 20);
        for (int i = 2; i < 18; i++)
            commit(8'h90 | 8'(i % 16), 8'(i));
        wait_idle();
    endtask

    task automatic t_hw_protect();
        int n;
        wp_pin <= 1'b1;
        saw_valid = 1'b0;
        xfer('{ctl(CTRL_NORMAL, 1'b0), 8'h90, 8'h55}, n);
        check(n, 3);
        check(busy, 1'b1);
        wait_idle();
        xfer('{ctl(CTRL_WPROT, 1'b0), 8'h00, 8'h00}, n);
        check(n, 3);
        wait_idle();
        check({saw_valid, wprot_set}, 2'b00);
        wp_pin <= 1'b0;
    endtask

    task automatic t_sw_protect();
        int n;
        xfer('{ctl(CTRL_WPROT, 1'b0), 8'h00, 8'h00}, n);
        check(n, 3);
        wait_idle();
        check(wprot_set, 1'b1);
        saw_valid = 1'b0;
        xfer('{ctl(CTRL_NORMAL, 1'b0), 8'h7F, 8'hA5}, n);
        check(n, 3);
        wait_idle();
        check(saw_valid, 1'b0);
        xfer('{ctl(CTRL_NORMAL, 1'b0), 8'h80, 8'h5A}, n);
        commit(8'h80, 8'h5A);
        wait_idle();
        xfer('{ctl(CTRL_WPROT, 1'b0)}, n);
        check(n, 0);
    endtask

    task automatic t_read();
        logic [7:0] a;
        logic [7:0] d0;
        logic [7:0] d1;
        logic k;
        a = rd_addr;
        m.start();
        m.write_byte(ctl(CTRL_NORMAL, 1'b1), k);
        check(k, 1'b1);
        check(sda_out, 1'b0);
        m.read_byte(1'b1, d0);
        m.read_byte(1'b0, d1);
        check(sda_oe, 1'b0);
        m.stop();
        check({d0, d1}, {~a, ~(a + 8'h01)});
        check(rd_addr, a + 8'h02);
    endtask

    // ==========================================================
    // Main sequence
    initial
    begin
        reset_n = 1'b0;
        strap = 3'h5;
        wp_pin = 1'b0;
        mem_ready = 1'b0;
        saw_valid = 1'b0;
        oe_prev = 1'b0;
        low_cnt = 0;
        err_count = 0;
        checks_done = 0;
        repeat (2) @(posedge clock);
        reset_n <= 1'b1;
        repeat (10) @(posedge clock);
        t_byte_write();
        t_select();
        t_page();
        t_hw_protect();
        t_sw_protect();
        t_read();
        summarize();
    end

    // Whole run needs about 41000 cycles
    initial
    begin
        repeat (90000) @(posedge clock);
        err_count++;
        summarize();
    end
endmodule
